/* hw/rhdte_pkg.sv */
/*
  package for the half-duplex transmit-enable block: mode byte fields,
  the pin count and reset values.
  assumes a single 50 MHz clock domain and no register bus.
*/
package rhdte_pkg;
  // ==========================================================
  // mode byte layout
  localparam int MODE_IF_LSB = 0;
  localparam int MODE_IF_W = 2;
  localparam logic [1:0] MODE_IF_SINGLE = 2'h0;
  localparam logic [1:0] MODE_IF_FOURWIRE = 2'h1;
  localparam logic [1:0] MODE_IF_TWOWIRE = 2'h3;
  localparam logic [7:0] MODE_RESET = 8'h4C;
  // ==========================================================
  // pin routing and counts
  localparam int NUM_PINS = 3;
  localparam logic [1:0] PIN_SEL_RESET = 2'h0;
  localparam logic POL_RESET = 1'b1;
  // ==========================================================
  // configuration carrier
  typedef struct packed {
    logic [7:0] mode;     // interface mode byte
    logic [1:0] pin_sel;  // 0..2 selects the pin for the enable
    logic active_high;    // 1: enable high on pin
  } rhdte_cfg_t;
endpackage

/* hw/rhdte_top.sv */
/*
  transmit-enable control for a serial port driving an external
  two-wire half-duplex transceiver.
  assumes the serial transmitter and receiver sit on the same clock and
  report their state by level signals; the pin pads are external.
*/
`timescale 1ns/10ps
module rhdte_top #(
  parameter int NPINS = rhdte_pkg::NUM_PINS
) (
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  // configuration
  input wire logic [7:0] I_MODE,
  input wire logic [1:0] I_PIN_SEL,
  input wire logic I_ACTIVE_HIGH,
  input wire logic I_CFG_LOAD,
  // serial transmitter status
  input wire logic I_TX_PENDING,
  input wire logic I_TX_BUSY,
  // receive line from the transceiver
  input wire logic I_RX_LINE,
  // configurable pins
  input wire logic [NPINS-1:0] I_PIN_IN,
  output logic [NPINS-1:0] O_PIN_OUT,
  output logic [NPINS-1:0] O_PIN_OE_N,
  // status
  output logic O_DRIVER_EN,
  output logic O_TWO_WIRE,
  output logic O_SETUP_ALLOWED,
  output logic O_RX_LINE,
  output logic [NPINS-1:0] O_PIN_SYNC
);

  // ==========================================================
  // configuration latch
  rhdte_pkg::rhdte_cfg_t cfg_q;
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      cfg_q.mode <= rhdte_pkg::MODE_RESET;
      cfg_q.pin_sel <= rhdte_pkg::PIN_SEL_RESET;
      cfg_q.active_high <= rhdte_pkg::POL_RESET;
    end else if (I_CFG_LOAD) begin
      cfg_q.mode <= I_MODE;
      cfg_q.pin_sel <= I_PIN_SEL;
      cfg_q.active_high <= I_ACTIVE_HIGH;
    end
  end

  // mode decode
  logic [1:0] if_mode;
  logic two_wire;
  assign if_mode = cfg_q.mode[rhdte_pkg::MODE_IF_LSB +: rhdte_pkg::MODE_IF_W];
  assign two_wire = (if_mode == rhdte_pkg::MODE_IF_TWOWIRE);

  // ==========================================================
  // enable state machine
  typedef enum logic [1:0] {ST_IDLE, ST_SEND} rhdte_state_t;
  rhdte_state_t state_q;
  rhdte_state_t state_d;
  logic drv_en_q;

  // next state: pending or shifting data holds the line in two-wire mode
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (two_wire && (I_TX_PENDING || I_TX_BUSY)) begin
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (!two_wire || (!I_TX_PENDING && !I_TX_BUSY)) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // registered enable, same edge as the pin so both rise and fall together
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      drv_en_q <= 1'b0;
    end else begin
      drv_en_q <= (state_d == ST_SEND);
    end
  end

  // ==========================================================
  // pin input synchronisers
  logic [NPINS-1:0] pin_s1_q;
  logic [NPINS-1:0] pin_s2_q;
  logic rx_s1_q;
  logic rx_s2_q;
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      pin_s1_q <= I_PIN_IN;
      pin_s2_q <= pin_s1_q;
      rx_s1_q <= I_RX_LINE;
      rx_s2_q <= rx_s1_q;
    end
  end

  // receive masked to idle while transmitting
  logic rx_q;
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      rx_q <= 1'b1;
    end else begin
      rx_q <= drv_en_q ? 1'b1 : rx_s2_q;
    end
  end

  // ==========================================================
  // pin routing, one pin carries the enable
  logic [NPINS-1:0] pin_out_q;
  logic [NPINS-1:0] pin_oe_n_q;
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      always_ff @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
          pin_out_q[g] <= 1'b0;
          pin_oe_n_q[g] <= 1'b1;
        end else if (two_wire && (cfg_q.pin_sel == 2'(g))) begin
          pin_oe_n_q[g] <= 1'b0;
          pin_out_q[g] <= (state_d == ST_SEND) ? cfg_q.active_high : !cfg_q.active_high;
        end else begin
          pin_oe_n_q[g] <= 1'b1;
          pin_out_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // outputs
  assign O_PIN_OUT = pin_out_q;
  assign O_PIN_OE_N = pin_oe_n_q;
  assign O_DRIVER_EN = drv_en_q;
  assign O_TWO_WIRE = two_wire;
  assign O_SETUP_ALLOWED = (if_mode == rhdte_pkg::MODE_IF_SINGLE);
  assign O_RX_LINE = rx_q;
  assign O_PIN_SYNC = pin_s2_q;

  // ==========================================================
  // assertions
  sequence s_start;
    two_wire && I_TX_PENDING;
  endsequence
  sequence s_done;
    !I_TX_PENDING && !I_TX_BUSY;
  endsequence

  property p_only_two_wire;
    @(posedge I_MCLK) disable iff (I_SYS_RST) !$past(two_wire) |-> !drv_en_q;
  endproperty
  a_only_two_wire: assert property (p_only_two_wire) else $error("enable outside two-wire mode");

  property p_auto_on;
    @(posedge I_MCLK) disable iff (I_SYS_RST) s_start |=> drv_en_q;
  endproperty
  a_auto_on: assert property (p_auto_on) else $error("enable not raised for pending data");

  property p_auto_off;
    @(posedge I_MCLK) disable iff (I_SYS_RST) s_done |=> !drv_en_q;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("enable not released after send");

  property p_one_pin;
    @(posedge I_MCLK) disable iff (I_SYS_RST) $countones(~pin_oe_n_q) <= 1;
  endproperty
  a_one_pin: assert property (p_one_pin) else $error("more than one pin carries the enable");

  property p_polarity;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      drv_en_q && int'(cfg_q.pin_sel) < NPINS && !pin_oe_n_q[cfg_q.pin_sel] && $stable(cfg_q)
      |-> pin_out_q[cfg_q.pin_sel] == cfg_q.active_high;
  endproperty
  a_polarity: assert property (p_polarity) else $error("enable pin level wrong");

  property p_idle_inactive;
    @(posedge I_MCLK) disable iff (I_SYS_RST)
      !drv_en_q && int'(cfg_q.pin_sel) < NPINS && !pin_oe_n_q[cfg_q.pin_sel] && $stable(cfg_q)
      |-> pin_out_q[cfg_q.pin_sel] != cfg_q.active_high;
  endproperty
  a_idle_inactive: assert property (p_idle_inactive) else $error("enable pin active while idle");

  property p_setup;
    @(posedge I_MCLK) disable iff (I_SYS_RST) (cfg_q.mode[1] || cfg_q.mode[0]) |-> !O_SETUP_ALLOWED;
  endproperty
  a_setup: assert property (p_setup) else $error("setup offered in differential mode");

  property p_mode_decode;
    @(posedge I_MCLK) disable iff (I_SYS_RST) two_wire == (cfg_q.mode[1] && cfg_q.mode[0]);
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("two-wire decode wrong");

  property p_rx_mask;
    @(posedge I_MCLK) disable iff (I_SYS_RST) drv_en_q |=> rx_q;
  endproperty
  a_rx_mask: assert property (p_rx_mask) else $error("receive not masked while sending");

  property p_pins_off;
    @(posedge I_MCLK) disable iff (I_SYS_RST) !$past(two_wire) |-> &pin_oe_n_q;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("pin driven outside two-wire mode");

  property p_no_route;
    @(posedge I_MCLK) disable iff (I_SYS_RST) int'($past(cfg_q.pin_sel)) >= NPINS |-> &pin_oe_n_q;
  endproperty
  a_no_route: assert property (p_no_route) else $error("pin driven with no pin selected");

  property p_rx_pass;
    @(posedge I_MCLK) disable iff (I_SYS_RST) !drv_en_q |=> rx_q == $past(rx_s2_q);
  endproperty
  a_rx_pass: assert property (p_rx_pass) else $error("receive not passed while idle");

endmodule // rhdte_top

/* testbench/rhdte_top_bench.sv */
/*
  bench for the transmit-enable block: config, transmit and receive runs.
  assumes the transceiver model is compiled before it.
*/
`timescale 1ns/10ps
module rhdte_top_bench;
  logic mclk = 1'b0;
  logic rst, load, pend, busy, remote, pol, drv, two, setup, rx_o, line_en, rx;
  logic [7:0] mode;
  logic [1:0] sel;
  logic [2:0] pout, poe_n, pwire, psync;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  // ==========================================================
  // clock and hang limit
  initial begin
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end
  // ==========================================================
  // block and far side
  rhdte_top rhdte_top_i (.I_MCLK(mclk), .I_SYS_RST(rst), .I_MODE(mode), .I_PIN_SEL(sel),
    .I_ACTIVE_HIGH(pol), .I_CFG_LOAD(load), .I_TX_PENDING(pend), .I_TX_BUSY(busy),
    .I_RX_LINE(rx), .I_PIN_IN(pwire), .O_PIN_OUT(pout), .O_PIN_OE_N(poe_n),
    .O_DRIVER_EN(drv), .O_TWO_WIRE(two), .O_SETUP_ALLOWED(setup), .O_RX_LINE(rx_o), .O_PIN_SYNC(psync));
  rhdte_xcvr_model rhdte_xcvr_model_i (.i_pin_out(pout), .i_pin_oe_n(poe_n), .i_pin_idx(sel),
    .i_remote_bit(remote), .o_pin_wire(pwire), .o_line_drv_en(line_en), .o_rx(rx));
  // ==========================================================
  // shared tasks
  task automatic chk(input string name, input logic [2:0] exp, input logic [2:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic cfg(input logic [7:0] m, input logic [1:0] s, input logic p);
    mode = m;
    sel = s;
    pol = p;
    load = 1'b1;
    cyc(1);
    load = 1'b0;
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // test sequence
  initial begin
    rst = 1'b1;
    load = 1'b0;
    pend = 1'b0;
    busy = 1'b0;
    remote = 1'b1;
    mode = 8'h4C;
    sel = 2'h0;
    pol = 1'b1;
    cyc(5);
    rst = 1'b0;
    chk("oe_n", 3'h7, poe_n);
    chk("setup", 3'h1, 3'(setup));
    for (int m = 0; m < 2; m++) begin
      cfg(m ? 8'h5D : 8'h4C, 2'h0, 1'b1);
      pend = 1'b1;
      cyc(2);
      chk("drv", 3'h0, 3'(drv));
      chk("oe_n", 3'h7, poe_n);
      chk("setup", m ? 3'h0 : 3'h1, 3'(setup));
      pend = 1'b0;
    end
    remote = 1'b0;
    for (int s = 0; s < 3; s++) begin
      for (int p = 0; p < 2; p++) begin
        cfg(8'h4F, s[1:0], p[0]);
        chk("two", 3'h1, 3'(two));
        cyc(1);
        chk("oe_n", ~(3'h1 << s), poe_n);
        chk("idle", p ? 3'h0 : 3'h1 << s, pout);
        pend = 1'b1;
        cyc(1);
        pend = 1'b0;
        busy = 1'b1;
        chk("drv", 3'h1, 3'(drv));
        chk("act", p ? 3'h1 << s : 3'h0, pout);
        chk("line_en", 3'(p), 3'(line_en));
        cyc(3);
        chk("rx", 3'h1, 3'(rx_o));
        chk("pin_sync", p ? 3'h1 << s : 3'h0, psync);
        busy = 1'b0;
        cyc(1);
        chk("drv", 3'h0, 3'(drv));
        chk("rel", p ? 3'h0 : 3'h1 << s, pout);
        chk("line_en", 3'(p == 0), 3'(line_en));
        if (p == 1) begin
          cyc(3);
          chk("rx", 3'h0, 3'(rx_o));
        end
      end
    end
    cfg(8'h4F, 2'h1, 1'b1);
    pend = 1'b1;
    busy = 1'b1;
    cyc(2);
    chk("drv", 3'h1, 3'(drv));
    cfg(8'h4C, 2'h1, 1'b1);
    cyc(1);
    chk("drv", 3'h0, 3'(drv));
    chk("oe_n", 3'h7, poe_n);
    busy = 1'b0;
    cfg(8'h4F, 2'h3, 1'b1);
    cyc(2);
    chk("drv", 3'h1, 3'(drv));
    chk("oe_n", 3'h7, poe_n);
    pend = 1'b0;
    give_verdict();
  end
endmodule // rhdte_top_bench

/* testbench/rhdte_xcvr_model.sv */
/*
  behavioural line transceiver on the shared two-wire pair.
  assumes a high-active driver enable with the receiver enable tied to it.
*/
`timescale 1ns/10ps
module rhdte_xcvr_model (
  // pins from the block
  input wire logic [2:0] i_pin_out,
  input wire logic [2:0] i_pin_oe_n,
  input wire logic [1:0] i_pin_idx,
  // far nodes on the pair
  input wire logic i_remote_bit,
  // back to the block
  output logic [2:0] o_pin_wire,
  output logic o_line_drv_en,
  output logic o_rx
);
  // undriven pins settle on a pull-down
  assign o_pin_wire = i_pin_out & ~i_pin_oe_n;
  // driver joins the pair on a high enable
  assign o_line_drv_en = |(o_pin_wire & (3'h1 << i_pin_idx));
  // receiver output off while driving, pulled high
  assign o_rx = o_line_drv_en ? 1'b1 : i_remote_bit;
endmodule // rhdte_xcvr_model
